// ### src/adcctl_top.sv
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "adcctl_regs.svh"

module adcctl_top
	import adcctl_pkg::*;
(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  timer8_overflow,
	input  wire logic                  timer16_overflow,
	input  wire logic                  period_match,
	input  wire logic                  external_trigger_pin,
	input  wire adcctl_conv_in_t [1:0] conv_in,
	output adcctl_pad_ctl_t    [1:0]   pad_ctl,
	output logic      [2:0]            conversion_clock_select,
	output logic      [1:0]            positive_reference_select
);

	// ==========================================================
	// Register storage.
	logic          [7:0] ch_reg   [2];
	logic          [3:0] cfg_reg  [2];
	logic          [6:0] pre_reg  [2];
	logic          [6:0] acq_reg  [2];
	logic          [9:0] res_reg  [2][2];
	logic          [1:0] done_reg;
	logic          [1:0] go_reg;
	logic          [7:0] com_reg;
	logic          [2:0] trig_reg;
	logic                ext_prev_reg;
	adcctl_state_t       state_reg [2];
	logic          [6:0] cnt_reg   [2];
	logic          [1:0] samp_reg;
	logic          [1:0] conv_seen_reg;
	logic         [31:0] prdata_reg;

	logic                wr;
	logic                trig_event;
	logic          [1:0] finish;
	logic          [1:0] abort;
	logic                justify;

	assign wr      = psel && penable && pwrite;
	assign justify = com_reg[`ADCCTL_COM_JUSTIFY];

	assign conversion_clock_select   = com_reg[`ADCCTL_COM_CLK_LSB +: 3];
	assign positive_reference_select = com_reg[`ADCCTL_COM_PREF_LSB +: 2];

	// ==========================================================
	// Common and trigger registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			com_reg  <= `ADCCTL_RST_BYTE;
			trig_reg <= 3'h0;
		end else if (wr) begin
			if (paddr == `ADCCTL_OFS_COMMON) begin
				// The go-all bit is not stored; it reads back as the OR of go bits.
				com_reg <= pwdata[7:0] & 8'hf3;
			end
			if (paddr == `ADCCTL_OFS_TRIG) begin
				trig_reg <= pwdata[`ADCCTL_TRIG_LSB +: 3];
			end
		end
	end

	// ==========================================================
	// Auto-conversion trigger selection.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_prev_reg <= 1'b0;
		end else begin
			ext_prev_reg <= external_trigger_pin;
		end
	end

	always_comb begin
		case (adcctl_trig_t'(trig_reg))
			ADCCTL_TRIG_TMR8:  trig_event = timer8_overflow;
			ADCCTL_TRIG_TMR16: trig_event = timer16_overflow;
			ADCCTL_TRIG_PER:   trig_event = period_match;
			ADCCTL_TRIG_RISE:  trig_event = external_trigger_pin && !ext_prev_reg;
			ADCCTL_TRIG_FALL:  trig_event = !external_trigger_pin && ext_prev_reg;
			default:           trig_event = 1'b0;
		endcase
	end

	// ==========================================================
	// Per-converter sequencers, fully independent of each other.
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_conv
			logic [7:0]    ofs_ch;
			logic [7:0]    ofs_cfg;
			logic [7:0]    ofs_pre;
			logic [7:0]    ofs_acq;
			logic          on;
			logic          wr_ch;
			logic          set_go;
			logic          inv_now;
			logic          is_double;
			adcctl_state_t first_state;
			logic [6:0]    first_cnt;

			assign ofs_ch  = (gi == 0) ? `ADCCTL_OFS_CH1  : `ADCCTL_OFS_CH2;
			assign ofs_cfg = (gi == 0) ? `ADCCTL_OFS_CFG1 : `ADCCTL_OFS_CFG2;
			assign ofs_pre = (gi == 0) ? `ADCCTL_OFS_PRE1 : `ADCCTL_OFS_PRE2;
			assign ofs_acq = (gi == 0) ? `ADCCTL_OFS_ACQ1 : `ADCCTL_OFS_ACQ2;

			assign on        = ch_reg[gi][`ADCCTL_CH_ON];
			assign wr_ch     = wr && (paddr == ofs_ch);
			assign is_double = cfg_reg[gi][`ADCCTL_CFG_DOUBLE];
			assign inv_now   = cfg_reg[gi][`ADCCTL_CFG_INVERT] && samp_reg[gi];
			assign set_go    = on && (trig_event
				|| (wr && paddr == `ADCCTL_OFS_COMMON && pwdata[`ADCCTL_COM_GO_ALL])
				|| (wr_ch && pwdata[`ADCCTL_CH_GO]));

			assign finish[gi] = (state_reg[gi] == ADCCTL_CONV) && conv_in[gi].done
				&& !(is_double && !samp_reg[gi]);
			assign abort[gi]  = (state_reg[gi] != ADCCTL_IDLE) && !go_reg[gi];

			// Zero pre-charge skips straight to acquisition, zero acquisition to conversion.
			always_comb begin
				if (pre_reg[gi] != 7'h00) begin
					first_state = ADCCTL_PRE;
					first_cnt   = pre_reg[gi];
				end else if (acq_reg[gi] != 7'h00) begin
					first_state = ADCCTL_ACQ;
					first_cnt   = acq_reg[gi];
				end else begin
					first_state = ADCCTL_CONV;
					first_cnt   = 7'h00;
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ch_reg[gi]  <= `ADCCTL_RST_BYTE;
					cfg_reg[gi] <= 4'h0;
					pre_reg[gi] <= 7'h00;
					acq_reg[gi] <= 7'h00;
				end else if (wr) begin
					if (paddr == ofs_ch) begin
						// Go is kept in its own flop; bit 7 is unimplemented.
						ch_reg[gi] <= pwdata[7:0] & 8'h7d;
					end
					if (paddr == ofs_cfg) begin
						cfg_reg[gi] <= pwdata[3:0];
					end
					if (paddr == ofs_pre) begin
						pre_reg[gi] <= pwdata[6:0];
					end
					if (paddr == ofs_acq) begin
						acq_reg[gi] <= pwdata[6:0];
					end
				end
			end

			// A new start beats completion in the same cycle so no trigger is lost.
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					go_reg[gi] <= 1'b0;
				end else if (!on) begin
					go_reg[gi] <= 1'b0;
				end else if (set_go) begin
					go_reg[gi] <= 1'b1;
				end else if (wr_ch) begin
					go_reg[gi] <= 1'b0;
				end else if (finish[gi]) begin
					go_reg[gi] <= 1'b0;
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					state_reg[gi] <= ADCCTL_IDLE;
					cnt_reg[gi]   <= 7'h00;
					samp_reg[gi]  <= 1'b0;
				end else if (!on || abort[gi]) begin
					state_reg[gi] <= ADCCTL_IDLE;
					samp_reg[gi]  <= 1'b0;
				end else begin
					case (state_reg[gi])
						ADCCTL_IDLE: begin
							if (go_reg[gi]) begin
								state_reg[gi] <= first_state;
								cnt_reg[gi]   <= first_cnt;
								samp_reg[gi]  <= 1'b0;
							end
						end
						ADCCTL_PRE: begin
							if (cnt_reg[gi] == 7'h01) begin
								if (acq_reg[gi] != 7'h00) begin
									state_reg[gi] <= ADCCTL_ACQ;
									cnt_reg[gi]   <= acq_reg[gi];
								end else begin
									state_reg[gi] <= ADCCTL_CONV;
								end
							end else begin
								cnt_reg[gi] <= cnt_reg[gi] - 7'h01;
							end
						end
						ADCCTL_ACQ: begin
							if (cnt_reg[gi] == 7'h01) begin
								state_reg[gi] <= ADCCTL_CONV;
							end else begin
								cnt_reg[gi] <= cnt_reg[gi] - 7'h01;
							end
						end
						ADCCTL_CONV: begin
							if (conv_in[gi].done) begin
								if (is_double && !samp_reg[gi]) begin
									state_reg[gi] <= ADCCTL_GAP;
									cnt_reg[gi]   <= `ADCCTL_GAP_CYCLES;
									samp_reg[gi]  <= 1'b1;
								end else begin
									state_reg[gi] <= ADCCTL_IDLE;
									samp_reg[gi]  <= 1'b0;
								end
							end
						end
						ADCCTL_GAP: begin
							if (cnt_reg[gi] == 7'h01) begin
								state_reg[gi] <= first_state;
								cnt_reg[gi]   <= first_cnt;
							end else begin
								cnt_reg[gi] <= cnt_reg[gi] - 7'h01;
							end
						end
						default: begin
							state_reg[gi] <= ADCCTL_IDLE;
						end
					endcase
				end
			end

			// An aborted conversion still leaves its partial code in the result slot.
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					res_reg[gi][0] <= `ADCCTL_RST_RESULT;
					res_reg[gi][1] <= `ADCCTL_RST_RESULT;
				end else if (state_reg[gi] == ADCCTL_CONV && (conv_in[gi].done || abort[gi])) begin
					res_reg[gi][samp_reg[gi]] <= conv_in[gi].conversion_result;
				end
			end

			// Sticky done flag: write one to clear, a new completion wins.
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					done_reg[gi] <= 1'b0;
				end else if (finish[gi] && !abort[gi]) begin
					done_reg[gi] <= 1'b1;
				end else if (wr && paddr == `ADCCTL_OFS_STATUS && pwdata[gi]) begin
					done_reg[gi] <= 1'b0;
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					conv_seen_reg[gi] <= 1'b0;
				end else begin
					conv_seen_reg[gi] <= (state_reg[gi] == ADCCTL_CONV);
				end
			end

			// Outside pre-charge no bias path is ever on, so the hold charge stays put.
			always_comb begin
				pad_ctl[gi].channel        = ch_reg[gi][`ADCCTL_CH_SEL_LSB +: 5];
				pad_ctl[gi].converter_on   = on;
				pad_ctl[gi].mux_closed     = on && (state_reg[gi] != ADCCTL_PRE);
				pad_ctl[gi].hold_bias_en   = (state_reg[gi] == ADCCTL_PRE);
				pad_ctl[gi].hold_bias_high = cfg_reg[gi][`ADCCTL_CFG_HOLD_POL] ^ inv_now;
				pad_ctl[gi].pad_drive_en   = (state_reg[gi] == ADCCTL_PRE);
				pad_ctl[gi].pad_drive_high = cfg_reg[gi][`ADCCTL_CFG_PAD_POL] ^ inv_now;
				pad_ctl[gi].convert_start  = (state_reg[gi] == ADCCTL_CONV) && !conv_seen_reg[gi];
			end
		end
	endgenerate

	// ==========================================================
	// Result byte formatting.
	function automatic logic [7:0] adcctl_res_high(input logic [9:0] r, input logic j);
		adcctl_res_high = j ? {6'h00, r[9:8]} : r[9:2];
	endfunction

	function automatic logic [7:0] adcctl_res_low(input logic [9:0] r, input logic j);
		adcctl_res_low = j ? r[7:0] : {r[1:0], 6'h00};
	endfunction

	// ==========================================================
	// APB read path: data is captured in the setup cycle, no wait states.
	logic [7:0] rd_byte;
	logic       rd_hit;

	always_comb begin
		rd_hit  = 1'b1;
		rd_byte = 8'h00;
		case (paddr)
			`ADCCTL_OFS_CH1:     rd_byte = ch_reg[0] | {6'h00, go_reg[0], 1'b0};
			`ADCCTL_OFS_CH2:     rd_byte = ch_reg[1] | {6'h00, go_reg[1], 1'b0};
			`ADCCTL_OFS_COMMON:  rd_byte = com_reg | {5'h00, |go_reg, 2'h0};
			`ADCCTL_OFS_TRIG:    rd_byte = {1'b0, trig_reg, 4'h0};
			`ADCCTL_OFS_CFG1:    rd_byte = {4'h0, cfg_reg[0]};
			`ADCCTL_OFS_CFG2:    rd_byte = {4'h0, cfg_reg[1]};
			`ADCCTL_OFS_PRE1:    rd_byte = {1'b0, pre_reg[0]};
			`ADCCTL_OFS_ACQ1:    rd_byte = {1'b0, acq_reg[0]};
			`ADCCTL_OFS_PRE2:    rd_byte = {1'b0, pre_reg[1]};
			`ADCCTL_OFS_ACQ2:    rd_byte = {1'b0, acq_reg[1]};
			`ADCCTL_OFS_RES1_0H: rd_byte = adcctl_res_high(res_reg[0][0], justify);
			`ADCCTL_OFS_RES1_0L: rd_byte = adcctl_res_low(res_reg[0][0], justify);
			`ADCCTL_OFS_RES1_1H: rd_byte = adcctl_res_high(res_reg[0][1], justify);
			`ADCCTL_OFS_RES1_1L: rd_byte = adcctl_res_low(res_reg[0][1], justify);
			`ADCCTL_OFS_RES2_0H: rd_byte = adcctl_res_high(res_reg[1][0], justify);
			`ADCCTL_OFS_RES2_0L: rd_byte = adcctl_res_low(res_reg[1][0], justify);
			`ADCCTL_OFS_RES2_1H: rd_byte = adcctl_res_high(res_reg[1][1], justify);
			`ADCCTL_OFS_RES2_1L: rd_byte = adcctl_res_low(res_reg[1][1], justify);
			`ADCCTL_OFS_STATUS:  rd_byte = {state_reg[1], state_reg[0], done_reg};
			default:             rd_hit  = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata_reg <= {24'h00_0000, rd_byte};
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !rd_hit;

endmodule // adcctl_top

// ### src/adcctl_regs.svh
`ifndef ADCCTL_REGS_SVH
`define ADCCTL_REGS_SVH
// Notes on behaviour
// - Selector 110/111: external pin rising/falling edge starts.
// - Selector 100: 16-bit timer overflow starts conversion.
// - Left justify: bits 9:2 high, 1:0 low[7:6].
// - Right justify: bits 9:8 high[1:0], 7:0 low.
// - Hold capacitor never discharged between conversions.
// - Measurement start opens hold-to-sensor connection.
// - Pre-charge biases hold and drives sensor path.
// - Pre-charge end: bias off, hold reconnected, acquire.
// - After acquisition, settled hold voltage is converted.
// - Optional second pass with swapped pre-charge levels.
// - Separate result storage for both samples.
// - Both converters sequence independently at once.
// - Pre-charge lasts 1..127 cycles; zero skips it.
// - Acquisition 1..127 cycles, after pre-charge or start.
// - Completion clears go, sets done flag, stores result.
// - Second conversion begins two cycles after first.

// ==========================================================
// Register byte offsets.
`define ADCCTL_OFS_CH1      8'h00
`define ADCCTL_OFS_CH2      8'h04
`define ADCCTL_OFS_COMMON   8'h08
`define ADCCTL_OFS_TRIG     8'h0c
`define ADCCTL_OFS_CFG1     8'h10
`define ADCCTL_OFS_CFG2     8'h14
`define ADCCTL_OFS_PRE1     8'h18
`define ADCCTL_OFS_ACQ1     8'h1c
`define ADCCTL_OFS_PRE2     8'h20
`define ADCCTL_OFS_ACQ2     8'h24
`define ADCCTL_OFS_RES1_0H  8'h28
`define ADCCTL_OFS_RES1_0L  8'h2c
`define ADCCTL_OFS_RES1_1H  8'h30
`define ADCCTL_OFS_RES1_1L  8'h34
`define ADCCTL_OFS_RES2_0H  8'h38
`define ADCCTL_OFS_RES2_0L  8'h3c
`define ADCCTL_OFS_RES2_1H  8'h40
`define ADCCTL_OFS_RES2_1L  8'h44
`define ADCCTL_OFS_STATUS   8'h48

// ==========================================================
// Field positions.
`define ADCCTL_CH_ON        0
`define ADCCTL_CH_GO        1
`define ADCCTL_CH_SEL_LSB   2
`define ADCCTL_COM_PREF_LSB 0
`define ADCCTL_COM_GO_ALL   2
`define ADCCTL_COM_CLK_LSB  4
`define ADCCTL_COM_JUSTIFY  7
`define ADCCTL_TRIG_LSB     4
`define ADCCTL_CFG_DOUBLE   0
`define ADCCTL_CFG_INVERT   1
`define ADCCTL_CFG_HOLD_POL 2
`define ADCCTL_CFG_PAD_POL  3

// ==========================================================
// Reset values and timing counts.
`define ADCCTL_RST_BYTE     8'h00
`define ADCCTL_RST_RESULT   10'h000
`define ADCCTL_GAP_CYCLES   7'h02
`endif

// ### src/adcctl_pkg.sv
package adcctl_pkg;

	typedef enum logic [2:0] {
		ADCCTL_IDLE = 3'b000,
		ADCCTL_PRE  = 3'b001,
		ADCCTL_ACQ  = 3'b010,
		ADCCTL_CONV = 3'b011,
		ADCCTL_GAP  = 3'b100
	} adcctl_state_t;

	typedef enum logic [2:0] {
		ADCCTL_TRIG_NONE  = 3'b000,
		ADCCTL_TRIG_RSV1  = 3'b001,
		ADCCTL_TRIG_RSV2  = 3'b010,
		ADCCTL_TRIG_TMR8  = 3'b011,
		ADCCTL_TRIG_TMR16 = 3'b100,
		ADCCTL_TRIG_PER   = 3'b101,
		ADCCTL_TRIG_RISE  = 3'b110,
		ADCCTL_TRIG_FALL  = 3'b111
	} adcctl_trig_t;

	// Result handed back by the analog converter.
	typedef struct packed {
		logic       done;
		logic [9:0] conversion_result;
	} adcctl_conv_in_t;

	// Control of the sample path, hold capacitor and sensor pad.
	typedef struct packed {
		logic [4:0] channel;
		logic       converter_on;
		logic       mux_closed;
		logic       hold_bias_en;
		logic       hold_bias_high;
		logic       pad_drive_en;
		logic       pad_drive_high;
		logic       convert_start;
	} adcctl_pad_ctl_t;

endpackage

// ### verif/adcctl_chk.sv
`timescale 1ns/1ps
// ==========================================================
// Port checks of the bus answer and of each converter's pad sequencing.
module adcctl_chk
	import adcctl_pkg::*;
(
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire adcctl_conv_in_t [1:0] conv_in,
	input wire adcctl_pad_ctl_t [1:0] pad_ctl
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_apb_err_phase: assert property (pslverr |-> psel && penable)
		else $error("slave error outside an access phase");
	chk_apb_no_wait: assert property (psel && penable |-> pready)
		else $error("access phase was stalled");

	for (genvar g = 0; g < 2; g++) begin : g_cv
		sequence s_pre_end;
			$fell(pad_ctl[g].hold_bias_en) && pad_ctl[g].converter_on;
		endsequence
		sequence s_joined;
			pad_ctl[g].mux_closed && !pad_ctl[g].pad_drive_en && !pad_ctl[g].hold_bias_en;
		endsequence
		chk_pre_mux_open: assert property (pad_ctl[g].hold_bias_en |-> !pad_ctl[g].mux_closed)
			else $error("hold capacitor biased while joined to the pad");
		chk_pre_both_bias: assert property (pad_ctl[g].hold_bias_en == pad_ctl[g].pad_drive_en)
			else $error("hold bias and pad drive out of step");
		chk_pre_end_join: assert property (s_pre_end |-> s_joined)
			else $error("pre-charge ended without rejoining the pad");
		chk_conv_joined: assert property (pad_ctl[g].convert_start |-> s_joined)
			else $error("conversion started on an unsettled hold node");
		chk_start_pulse: assert property (pad_ctl[g].convert_start |=> !pad_ctl[g].convert_start)
			else $error("convert start longer than one cycle");
		chk_hold_kept: assert property (conv_in[g].done |=> !pad_ctl[g].hold_bias_en)
			else $error("hold capacitor rebiased right after completion");
		chk_gap_quiet: assert property (conv_in[g].done |=> !pad_ctl[g].convert_start [*2])
			else $error("second conversion started inside the gap");
	end
endmodule // adcctl_chk

bind adcctl_top adcctl_chk u_chk (
	.pclk    (pclk),
	.presetn (presetn),
	.psel    (psel),
	.penable (penable),
	.pready  (pready),
	.pslverr (pslverr),
	.conv_in (conv_in),
	.pad_ctl (pad_ctl)
);

// ### verif/adcctl_conv_model.sv
`timescale 1ns/1ps
// ==========================================================
// Converter and sensor pad: the settled level depends on how the pad was pre-charged.
module adcctl_conv_model
	import adcctl_pkg::*;
#(
	parameter int LAT = 4
)(
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire adcctl_pad_ctl_t pad,
	input  wire logic [9:0]      res_pad_high,
	input  wire logic [9:0]      res_pad_low,
	output adcctl_conv_in_t      conv
);
	int         cnt;
	logic       pad_high;
	logic [9:0] last;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt      <= 0;
			pad_high <= 1'b0;
			last     <= 10'h000;
			conv     <= '0;
		end else begin
			conv.done              <= 1'b0;
			// The result lines are not held between answers.
			conv.conversion_result <= ~last;
			if (pad.pad_drive_en) begin
				pad_high <= pad.pad_drive_high;
			end
			if (!pad.converter_on) begin
				cnt <= 0;
			end else if (pad.convert_start) begin
				cnt <= LAT;
			end else if (cnt == 1) begin
				cnt                    <= 0;
				conv.done              <= 1'b1;
				last                   <= pad_high ? res_pad_high : res_pad_low;
				conv.conversion_result <= pad_high ? res_pad_high : res_pad_low;
			end else if (cnt > 1) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule // adcctl_conv_model

// ### verif/tb.sv
`timescale 1ns/1ps
// ==========================================================
// Register-level regression of the converter control block.
module tb;
	import adcctl_pkg::*;
	localparam logic [9:0] R1  = 10'h2b5;
	localparam logic [9:0] RH  = 10'h3c3;
	localparam logic [9:0] RL  = 10'h0f0;
	localparam int         GAP = 2;
	logic                  pclk = 1'b0;
	logic                  presetn, psel, penable, pwrite, err;
	logic                  t8, t16, per, ext;
	logic [7:0]            paddr;
	logic [31:0]           pwdata, prdata, q;
	logic                  pready, pslverr;
	logic [2:0]            clk_sel;
	logic [1:0]            ref_sel, pb, hp1;
	wire adcctl_conv_in_t [1:0] conv_in;
	wire adcctl_pad_ctl_t [1:0] pad_ctl;
	int                    n_fail, checks_done, cyc;
	int                    nb[2], t_start[2], t_done[2], t_gap[2];
	int                    l0, l1, l2, l3, b0, b1, b2, b3;
	logic [9:0]            a0, a1, c0, c1;

	always #5 pclk = ~pclk;

	adcctl_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer8_overflow(t8), .timer16_overflow(t16),
		.period_match(per), .external_trigger_pin(ext), .conv_in(conv_in),
		.pad_ctl(pad_ctl), .conversion_clock_select(clk_sel),
		.positive_reference_select(ref_sel));
	adcctl_conv_model m0 (.pclk(pclk), .presetn(presetn), .pad(pad_ctl[0]),
		.res_pad_high(R1), .res_pad_low(R1), .conv(conv_in[0]));
	adcctl_conv_model m1 (.pclk(pclk), .presetn(presetn), .pad(pad_ctl[1]),
		.res_pad_high(RH), .res_pad_low(RL), .conv(conv_in[1]));

	// ==========================================================
	// Pad activity monitor.
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		for (int i = 0; i < 2; i++) begin
			pb[i] <= pad_ctl[i].hold_bias_en;
			if (pad_ctl[i].hold_bias_en === 1'b1) nb[i] <= nb[i] + 1;
			if (pad_ctl[i].convert_start === 1'b1) t_start[i] <= cyc;
			if (conv_in[i].done === 1'b1) t_done[i] <= cyc;
			if (pad_ctl[i].hold_bias_en === 1'b1 && pb[i] !== 1'b1) t_gap[i] <= cyc - t_done[i];
		end
		// Hold bias level at the start of each pre-charge of the second converter.
		if (pad_ctl[1].hold_bias_en === 1'b1 && pb[1] !== 1'b1) hp1 <= {hp1[0], pad_ctl[1].hold_bias_high};
	end

	// ==========================================================
	// Bus and checking tasks.
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r);
		int n;
		n = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge pclk);
		end
		r = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n == 20) chk(32'h0, 32'h1);
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		apb(1'b0, a, 32'h0, r);
	endtask

	task automatic wait_st(input logic [31:0] m);
		logic [31:0] r;
		int n;
		r = 32'h0;
		for (n = 0; n < 200 && (r & m) !== m; n++) rd(8'h48, r);
		chk(r & m, m);
	endtask

	// One single conversion on converter i; latency from go and biased cycles.
	task automatic run(input int i, input int pre, input int acq, output int lat, output int nbias);
		int b, t0;
		logic [7:0] base;
		base = (i == 0) ? 8'h18 : 8'h20;
		wr(base, 32'(pre));
		wr(base + 8'h04, 32'(acq));
		wr(8'h48, 32'h3);
		wr(8'(4 * i), 32'h1);
		repeat (5) @(posedge pclk);
		b = nb[i];
		wr(8'(4 * i), 32'h3);
		t0 = cyc;
		wait_st(32'(1 << i));
		lat = t_start[i] - t0;
		nbias = nb[i] - b;
	endtask

	task automatic dbl(input logic [7:0] cfg, output logic [9:0] s0, output logic [9:0] s1);
		logic [31:0] h, l;
		wr(8'h20, 32'h2);
		wr(8'h24, 32'h2);
		wr(8'h14, {24'h0, cfg});
		wr(8'h04, 32'h1);
		wr(8'h48, 32'h3);
		repeat (5) @(posedge pclk);
		wr(8'h08, 32'h84);
		wait_st(32'h3);
		chk(32'(t_gap[1]), 32'(1 + GAP));
		chk({30'h0, hp1}, 32'h1);
		rd(8'h38, h);
		rd(8'h3c, l);
		s0 = {h[1:0], l[7:0]};
		rd(8'h40, h);
		rd(8'h44, l);
		s1 = {h[1:0], l[7:0]};
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ==========================================================
	// Test sequence.
	initial begin
		{presetn, psel, penable, pwrite, t8, t16, per, ext} <= 8'h00;
		paddr  <= 8'h00;
		pwdata <= 32'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(8'h0c, q);
		chk(q, 32'h0);
		rd(8'h4c, q);
		chk({q[30:0], err}, 32'h1);
		wr(8'h08, 32'h53);
		chk({27'h0, clk_sel, ref_sel}, 32'h17);
		$display("test registers done");
		run(0, 0, 3, l0, b0);
		chk(32'(b0), 32'h0);
		run(0, 5, 3, l1, b1);
		chk(32'(l1 - l0), 32'h5);
		chk(32'(b1), 32'h5);
		rd(8'h28, q);
		chk(q, {24'h0, R1[9:2]});
		rd(8'h2c, q);
		chk(q & 32'hc0, {24'h0, R1[1:0], 6'h0});
		wr(8'h08, 32'hd3);
		rd(8'h28, q);
		chk(q & 32'h3, {30'h0, R1[9:8]});
		rd(8'h2c, q);
		chk(q, {24'h0, R1[7:0]});
		rd(8'h00, q);
		chk(q & 32'h2, 32'h0);
		run(0, 0, 7, l2, b2);
		chk(32'(l2 - l0), 32'h4);
		run(0, 127, 1, l3, b3);
		chk(32'(b3), 32'd127);
		$display("test timing done");
		dbl(8'h03, a0, a1);
		chk(32'(a0 == RH || a0 == RL), 32'h1);
		chk({22'h0, a0 ^ a1}, {22'h0, RH ^ RL});
		dbl(8'h0b, c0, c1);
		chk({22'h0, c0}, {22'h0, a1});
		chk({22'h0, c1}, {22'h0, a0});
		$display("test double done");
		wr(8'h04, 32'h7c);
		chk({26'h0, pad_ctl[1].channel, pad_ctl[1].converter_on}, 32'h3e);
		wr(8'h18, 32'h1);
		wr(8'h1c, 32'h1);
		for (int c = 0; c < 8; c++) begin
			wr(8'h0c, 32'(c << 4));
			for (int e = 0; e < 5; e++) begin
				wr(8'h48, 32'h3);
				case (e)
					0: t8 <= 1'b1;
					1: t16 <= 1'b1;
					2: per <= 1'b1;
					3: ext <= 1'b1;
					default: ext <= 1'b0;
				endcase
				@(posedge pclk);
				{t8, t16, per} <= 3'b000;
				repeat (30) @(posedge pclk);
				rd(8'h48, q);
				chk(q & 32'h1, 32'(c >= 3 && e == c - 3));
			end
		end
		$display("test triggers done");
		conclude();
	end

	initial begin
		#300000;
		n_fail++;
		conclude();
	end
endmodule // tb
